/* File: hdl/poll_master.sv */
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps

// Functional notes
// - Poll interval word counts 10 ms units.
// - Error bit stands one scan; bit 0 zero.
// - No error output; masks differing shows faults.
// - Offline flag while no slave communicates.
// - Offline when absent, online on good exchange.
// - Serve all online, then probe one offline.
// - Handshake reply waited for at most 30 ms.
// - Offline slaves add at most one probe.
// - After reset, probe registered slaves ascending.
// - Missed normal reply: skip to next slave.
// - Retry next scan; second miss goes offline.
// - Registration mask one bit per slave.
// - Online mask one only for online slaves.
module poll_master
    import poll_master_pkg::*;
#(
    parameter int          TICK_CYCLES  = TICK_CYC,
    parameter int          HS_TMO_CYCLES = HS_TMO_CYC,
    parameter int          NRM_TMO_CYCLES = HS_TMO_CYC,
    parameter logic [15:0] REG_MASK_INIT = REG_MASK_RST
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_xact_req,
    output logic                   o_xact_hs,
    output logic      [IDX_W-1:0]  o_xact_slave,
    input  wire logic              i_xact_done,
    input  wire logic              i_xact_ok,
    output logic                   o_link_offline,
    output logic                   o_irq
);

    scan_state_e       state_reg;
    logic [MASK_W-1:0] reg_mask_reg;
    logic [MASK_W-1:0] online_reg;
    logic [MASK_W-1:0] fail_reg;
    logic [MASK_W-1:0] err_acc_reg;
    logic [MASK_W-1:0] err_reg;
    logic [15:0]       poll_int_reg;
    logic [15:0]       tick_cnt_reg;
    logic [IDX_W-1:0]  cursor_reg;
    logic [IDX_W-1:0]  rr_reg;
    logic [TMO_W-1:0]  tmo_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic [IRQ_W-1:0]  irq_ev;
    logic              tick;
    logic              on_found;
    logic [IDX_W-1:0]  on_idx;
    logic              off_found;
    logic [IDX_W-1:0]  off_idx;
    logic              tmo_hit;
    logic              reply;
    logic              reply_ok;
    logic              wr_hit_mask;

    tick_divider #(.DIV(TICK_CYCLES), .CNT_W(TICK_W)) u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .o_tick    (tick)
    );

    // Next online slave above the cursor, strictly ascending.
    slot_finder #(.W(MASK_W), .IW(IDX_W), .WRAP(1'b0)) u_on_find (
        .i_mask  (online_reg),
        .i_start (cursor_reg),
        .o_found (on_found),
        .o_idx   (on_idx)
    );

    // Next registered but offline slave after the last probed one, wrapping.
    slot_finder #(.W(MASK_W), .IW(IDX_W), .WRAP(1'b1)) u_off_find (
        .i_mask  (reg_mask_reg & ~online_reg),
        .i_start (rr_reg),
        .o_found (off_found),
        .o_idx   (off_idx)
    );

    // A reply or a timeout closes the wait; a late reply after a timeout is not filtered and closes the next open wait.
    assign tmo_hit  = (state_reg == S_WAIT_OFF) ? (tmo_reg == TMO_W'(HS_TMO_CYCLES - 1))
                                               : (tmo_reg == TMO_W'(NRM_TMO_CYCLES - 1));
    assign reply    = i_xact_done | tmo_hit;
    assign reply_ok = i_xact_done & i_xact_ok;
    assign wr_hit_mask = i_wr_stb && (i_addr == OFS_REG_MASK);

    // Scan sequencer: online slaves first, then one probe, then the scan ends.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg  <= S_IDLE;
            cursor_reg <= '0;
            rr_reg     <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    state_reg  <= S_PICK_ON;
                    cursor_reg <= '0;
                end
                S_PICK_ON: begin
                    if (on_found) begin
                        cursor_reg <= on_idx;
                        state_reg  <= S_WAIT_ON;
                    end else begin
                        state_reg  <= S_PICK_OFF;
                    end
                end
                S_WAIT_ON: begin
                    if (reply) begin
                        state_reg <= S_PICK_ON;
                    end
                end
                S_PICK_OFF: begin
                    if (off_found) begin
                        rr_reg    <= off_idx;
                        state_reg <= S_WAIT_OFF;
                    end else begin
                        state_reg <= S_END;
                    end
                end
                S_WAIT_OFF: begin
                    if (reply) begin
                        state_reg <= S_END;
                    end
                end
                S_END: begin
                    cursor_reg <= '0;
                    state_reg  <= S_PICK_ON;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Request strobe towards the line driver, one cycle per transaction.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_xact_req   <= 1'b0;
            o_xact_hs    <= 1'b0;
            o_xact_slave <= '0;
        end else begin
            o_xact_req <= 1'b0;
            if (state_reg == S_PICK_ON && on_found) begin
                o_xact_req   <= 1'b1;
                o_xact_hs    <= 1'b0;
                o_xact_slave <= on_idx;
            end else if (state_reg == S_PICK_OFF && off_found) begin
                o_xact_req   <= 1'b1;
                o_xact_hs    <= 1'b1;
                o_xact_slave <= off_idx;
            end
        end
    end

    // Reply timer; restarted on every request so each wait gets its full budget.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || o_xact_req || reply) begin
            tmo_reg <= '0;
        end else if (state_reg == S_WAIT_ON || state_reg == S_WAIT_OFF) begin
            tmo_reg <= tmo_reg + 1'b1;
        end
    end

    // Online and retry bookkeeping. Deregistering a slave drops it at once.
    // The mask write comes first so that a drop or a join in the same cycle is not lost.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            online_reg <= '0;
            fail_reg   <= '0;
        end else begin
            if (wr_hit_mask) begin
                online_reg <= online_reg & i_wr_data & SLOT0_CLEAR;
            end
            if (state_reg == S_WAIT_ON && reply) begin
                if (reply_ok) begin
                    fail_reg[cursor_reg] <= 1'b0;
                end else if (fail_reg[cursor_reg]) begin
                    online_reg[cursor_reg] <= 1'b0;
                    fail_reg[cursor_reg]   <= 1'b0;
                end else begin
                    fail_reg[cursor_reg] <= 1'b1;
                end
            end else if (state_reg == S_WAIT_OFF && reply && reply_ok) begin
                online_reg[rr_reg] <= wr_hit_mask ? i_wr_data[rr_reg] : reg_mask_reg[rr_reg];
                fail_reg[rr_reg]   <= 1'b0;
            end
        end
    end

    // Registration mask, written by software; slot 0 never holds a one.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            reg_mask_reg <= REG_MASK_INIT & SLOT0_CLEAR;
        end else if (wr_hit_mask) begin
            reg_mask_reg <= i_wr_data & SLOT0_CLEAR;
        end
    end

    // Errors gather during a scan and are shown for exactly the next one.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            err_acc_reg <= '0;
            err_reg     <= '0;
        end else if (state_reg == S_END) begin
            err_reg     <= err_acc_reg & SLOT0_CLEAR;
            err_acc_reg <= '0;
        end else if (state_reg == S_WAIT_ON && reply && !reply_ok) begin
            err_acc_reg[cursor_reg] <= 1'b1;
        end
    end

    // Scan period in 10 ms units, saturating, latched at each scan end.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tick_cnt_reg <= '0;
            poll_int_reg <= '0;
        end else if (state_reg == S_END) begin
            poll_int_reg <= tick_cnt_reg;
            tick_cnt_reg <= '0;
        end else if (tick && tick_cnt_reg != 16'hffff) begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // Offline indication follows the online mask, so it drops on the first good exchange.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_link_offline <= 1'b1;
        end else begin
            o_link_offline <= (online_reg == '0);
        end
    end

    // Interrupt events; a fault shows only as status, never as a separate error pin.
    assign irq_ev[IRQ_ONLINE]  = (state_reg == S_WAIT_OFF) && reply_ok;
    assign irq_ev[IRQ_OFFLINE] = (state_reg == S_WAIT_ON) && reply && !reply_ok && fail_reg[cursor_reg];
    assign irq_ev[IRQ_ERROR]   = (state_reg == S_WAIT_ON) && reply && !reply_ok;

    // Sticky status; a new event beats a write-one-to-clear in the same cycle.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= IRQ_MASK_RST;
        end else begin
            if (i_wr_stb && i_addr == OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~i_wr_data[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            if (i_wr_stb && i_addr == OFS_IRQ_MASK) begin
                irq_mask_reg <= i_wr_data[IRQ_W-1:0];
            end
        end
    end

    // Level interrupt, one cycle behind the status it reflects.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read data stands in the cycle after the strobe only; unmapped reads return zero.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !i_rd_stb) begin
            o_rd_data <= '0;
        end else begin
            case (i_addr)
                OFS_REG_MASK:  o_rd_data <= reg_mask_reg;
                OFS_ONLINE:    o_rd_data <= online_reg;
                OFS_ERR_PULSE: o_rd_data <= err_reg;
                OFS_POLL_INT:  o_rd_data <= poll_int_reg;
                OFS_IRQ_STAT:  o_rd_data <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
                OFS_IRQ_MASK:  o_rd_data <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
                default:       o_rd_data <= '0;
            endcase
        end
    end

    // Probes issued per scan; only the checks below read it.
    logic [IDX_W-1:0] probe_cnt_reg;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_reg == S_END) begin
            probe_cnt_reg <= '0;
        end else if (o_xact_req && o_xact_hs) begin
            probe_cnt_reg <= probe_cnt_reg + 1'b1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_slot0_zero: assert property (!online_reg[0] && !err_reg[0] && !reg_mask_reg[0])
        else $error("slot 0 bit set in a mask");
    a_online_subset: assert property ((online_reg & ~reg_mask_reg) == '0)
        else $error("online slave not registered");
    a_one_probe: assert property (probe_cnt_reg <= 1)
        else $error("more than one probe in a scan");
    a_hs_timeout: assert property (state_reg == S_WAIT_OFF |-> tmo_reg < TMO_W'(HS_TMO_CYCLES))
        else $error("handshake wait exceeded limit");
    a_err_stable: assert property (state_reg != S_END |=> $stable(err_reg))
        else $error("error word changed mid scan");
    a_second_miss: assert property (state_reg == S_WAIT_ON && reply && !reply_ok
                                    && fail_reg[cursor_reg] |=> !online_reg[$past(cursor_reg)])
        else $error("second miss left slave online");
    a_skip_next: assert property (state_reg == S_WAIT_ON && reply |=> state_reg == S_PICK_ON)
        else $error("failed slave not skipped");
    a_ascending: assert property (o_xact_req && !o_xact_hs |-> o_xact_slave > $past(cursor_reg))
        else $error("normal poll out of order");
    a_offline_flag: assert property ((online_reg == '0) |=> o_link_offline)
        else $error("offline flag missing");
    a_irq_level: assert property (1'b1 |=> o_irq == $past(|(irq_stat_reg & irq_mask_reg)))
        else $error("interrupt level wrong");

    c_probe_ok: cover property (state_reg == S_WAIT_OFF && reply_ok);
    c_second_miss: cover property (irq_ev[IRQ_OFFLINE]);
    c_err_shown: cover property (err_reg != '0);
    c_irq: cover property (o_irq);

endmodule : poll_master

/* File: hdl/poll_master_pkg.sv */
package poll_master_pkg;

    // Link geometry.
    localparam int          N_SLAVES    = 15;
    localparam int          MASK_W      = 16;
    localparam int          IDX_W       = 4;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 16;

    // Register word offsets.
    localparam logic [3:0]  OFS_REG_MASK  = 4'h0;
    localparam logic [3:0]  OFS_ONLINE    = 4'h1;
    localparam logic [3:0]  OFS_ERR_PULSE = 4'h2;
    localparam logic [3:0]  OFS_POLL_INT  = 4'h3;
    localparam logic [3:0]  OFS_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  OFS_IRQ_MASK  = 4'h5;

    // Reset values and the slot 0 clearing mask.
    localparam logic [15:0] REG_MASK_RST  = 16'hfffe;
    localparam logic [15:0] SLOT0_CLEAR   = 16'hfffe;
    localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

    // Interrupt status bit positions.
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_ONLINE    = 0;
    localparam int          IRQ_OFFLINE   = 1;
    localparam int          IRQ_ERROR     = 2;

    // Timing: times in their own unit, cycle counts derived from the 10 MHz clock.
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          TICK_MS       = 10;
    localparam int          HS_TMO_MS     = 30;
    localparam int          TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int          HS_TMO_CYC    = CLK_HZ / 1000 * HS_TMO_MS;
    localparam int          TICK_W        = 17;
    localparam int          TMO_W         = 20;

    // Scan sequencer states, Gray coded in listing order; S_PICK_ON to S_PICK_OFF, S_PICK_OFF to S_END and S_END to S_PICK_ON flip two bits.
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_PICK_ON  = 3'b001,
        S_WAIT_ON  = 3'b011,
        S_PICK_OFF = 3'b010,
        S_WAIT_OFF = 3'b110,
        S_END      = 3'b111
    } scan_state_e;

endpackage : poll_master_pkg

/* File: hdl/tick_divider.sv */
`timescale 1ns/100ps

// Divides the reference clock into a one-cycle enable pulse every DIV cycles.
module tick_divider #(
    parameter int DIV   = 100000,
    parameter int CNT_W = 17
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    output logic      o_tick
);

    logic [CNT_W-1:0] cnt_reg;

    // Free running count; the pulse marks the wrap.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_reg <= '0;
            o_tick  <= 1'b0;
        end else if (cnt_reg == CNT_W'(DIV - 1)) begin
            cnt_reg <= '0;
            o_tick  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            o_tick  <= 1'b0;
        end
    end

endmodule : tick_divider

/* File: hdl/slot_finder.sv */
`timescale 1ns/100ps

// Finds the lowest set bit above a start index, optionally wrapping to bit 1.
module slot_finder #(
    parameter int W    = 16,
    parameter int IW   = 4,
    parameter bit WRAP = 1'b0
) (
    input  wire logic [W-1:0]  i_mask,
    input  wire logic [IW-1:0] i_start,
    output logic               o_found,
    output logic [IW-1:0]      o_idx
);

    // Scanning downward leaves the lowest qualifying index as the winner.
    always_comb begin
        o_found = 1'b0;
        o_idx   = '0;
        if (WRAP) begin
            for (int k = W - 1; k >= 1; k--) begin
                if (i_mask[k]) begin
                    o_found = 1'b1;
                    o_idx   = IW'(k);
                end
            end
        end
        for (int k = W - 1; k >= 1; k--) begin
            if (i_mask[k] && (IW'(k) > i_start)) begin
                o_found = 1'b1;
                o_idx   = IW'(k);
            end
        end
    end

endmodule : slot_finder

/* File: tb/slave_link_model.sv */
`timescale 1ns/100ps

// Stands in for the slave terminals: a present slave answers after a chosen delay, an absent one is silent.
module slave_link_model
    import poll_master_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic              i_xact_req,
    input  wire logic [IDX_W-1:0]  i_xact_slave,
    input  wire logic [MASK_W-1:0] i_alive,
    input  wire logic [2:0]        i_reply_dly,
    output logic                   o_xact_done,
    output logic                   o_xact_ok
);
    logic       busy_reg;
    logic [2:0] cnt_reg;
    logic       noise_reg;

    // One transaction at a time; silence is the only way an absent slave fails.
    always_ff @(posedge i_ref_clk) begin
        o_xact_done <= 1'b0;
        noise_reg   <= ~noise_reg;
        if (i_rst) begin
            busy_reg  <= 1'b0;
            noise_reg <= 1'b0;
        end else if (i_xact_req) begin
            busy_reg <= i_alive[i_xact_slave];
            cnt_reg  <= i_reply_dly;
        end else if (busy_reg) begin
            if (cnt_reg == 3'h0) begin
                o_xact_done <= 1'b1;
                busy_reg    <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end

    // The reply flag means nothing outside the done pulse, so it toggles there rather than holding.
    assign o_xact_ok = o_xact_done ? 1'b1 : noise_reg;
endmodule : slave_link_model

/* File: tb/tb.sv */
`timescale 1ns/100ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end

// Drives the register port, lets the slave model answer the link, and checks what the master reports.
module tb;
    import poll_master_pkg::*;

    localparam int HS_TMO  = 20;
    localparam int NRM_TMO = 20;

    logic              ref_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_stb;
    logic              rd_stb;
    logic [DATA_W-1:0] rd_data;
    logic              xact_req;
    logic              xact_hs;
    logic [IDX_W-1:0]  xact_slave;
    logic              xact_done;
    logic              xact_ok;
    logic              link_offline;
    logic              irq;
    logic [MASK_W-1:0] alive;
    logic [2:0]        reply_dly;
    logic              chk_stb;
    logic              chk_d = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] exp_rd;
    logic [IDX_W-1:0]  exp_prb[4] = '{4'h1, 4'h2, 4'h3, 4'h1};
    logic [IDX_W-1:0]  last_norm;
    logic [31:0]       seed = 32'h17;
    int                num_errors = 0;
    int                compares = 0;
    int                probes = 0;
    int                nprb = 0;
    int                gap = 0;
    bit                last_hs = 1'b0;
    bit                have_norm = 1'b0;

    poll_master #(.TICK_CYCLES(10), .HS_TMO_CYCLES(HS_TMO), .NRM_TMO_CYCLES(NRM_TMO)) u_poll_master (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wr_data), .i_wr_stb(wr_stb),
        .i_rd_stb(rd_stb), .o_rd_data(rd_data), .o_xact_req(xact_req), .o_xact_hs(xact_hs),
        .o_xact_slave(xact_slave), .i_xact_done(xact_done), .i_xact_ok(xact_ok),
        .o_link_offline(link_offline), .o_irq(irq));

    slave_link_model u_slave_link_model (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_xact_req(xact_req), .i_xact_slave(xact_slave),
        .i_alive(alive), .i_reply_dly(reply_dly), .o_xact_done(xact_done), .o_xact_ok(xact_ok));

    // Free-running reference clock.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y  = x ^ (x << 13);
        y  = y ^ (y >> 17);
        xs = y ^ (y << 5);
    endfunction : xs

    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= v;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask : wr

    // A checked read leaves its expectation in the queue; the monitor compares it when the data stand.
    task automatic rd(input logic [3:0] a, input bit chk, input logic [15:0] e, output logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        rd_stb  <= 1'b1;
        chk_stb <= chk;
        if (chk) exp_q.push_back(e);
        @(posedge ref_clk);
        rd_stb  <= 1'b0;
        chk_stb <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    // Polls a register under a bound; running out counts as a mismatch and ends the run.
    task automatic wait_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
        logic [15:0] d;
        bit          hit;
        hit = 1'b0;
        for (int i = 0; i < 400 && !hit; i++) begin
            rd(a, 1'b0, 16'h0000, d);
            hit = ((d & m) === v);
        end
        if (!hit) begin
            num_errors++;
            $display("mismatch at %0t: wait on register %0h ran out", $time, a);
            end_sim();
        end
    endtask : wait_reg

    // Read data stand only in the cycle after the strobe, so they are compared exactly there.
    always @(posedge ref_clk) begin
        chk_d <= chk_stb;
        if (chk_d) begin
            exp_rd = exp_q.pop_front();
            `CHK(rd_data, exp_rd)
        end
    end

    // Link watcher; it also feeds a fresh random reply delay to the slave model every cycle.
    always @(posedge ref_clk) begin
        seed = xs(seed);
        reply_dly <= seed[2:0];
        gap++;
        if (!rst && xact_req) begin
            if (last_hs) `CHK(gap <= HS_TMO + 6, 1'b1)
            if (xact_hs) begin
                if (nprb < 4) `CHK(xact_slave, exp_prb[nprb])
                nprb++;
                probes++;
            end else begin
                if (have_norm) `CHK(probes <= 1, 1'b1)
                if (have_norm && probes == 0) `CHK(xact_slave > last_norm, 1'b1)
                last_norm = xact_slave;
                have_norm = 1'b1;
                probes    = 0;
            end
            last_hs = xact_hs;
            gap     = 0;
        end
    end

    // Watchdog so a hung sequence still reaches the verdict.
    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        end_sim();
    end

    initial begin
        logic [15:0] d;
        rst = 1'b1; addr = 4'h0; wr_data = 16'h0000; wr_stb = 1'b0; rd_stb = 1'b0; chk_stb = 1'b0;
        alive = 16'h000c;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        // Register slaves 1 to 3, slave 1 absent; bit 0 must not stick.
        wr(OFS_REG_MASK, 16'h000f);
        rd(OFS_REG_MASK, 1'b1, 16'h000e, d);
        rd(OFS_ONLINE, 1'b1, 16'h0000, d);
        rd(4'hf, 1'b1, 16'h0000, d);
        `CHK(link_offline, 1'b1)
        wr(OFS_ONLINE, 16'hffff);
        wr(OFS_IRQ_MASK, 16'h0007);
        wait_reg(OFS_ONLINE, 16'hffff, 16'h000c);
        rd(OFS_ONLINE, 1'b1, 16'h000c, d);
        rd(OFS_IRQ_STAT, 1'b1, 16'h0001, d);
        rd(OFS_IRQ_MASK, 1'b1, 16'h0007, d);
        `CHK(link_offline, 1'b0)
        `CHK(irq, 1'b1)
        rd(OFS_POLL_INT, 1'b0, 16'h0000, d);
        `CHK(d > 16'h0000 && d < 16'h0010, 1'b1)
        wr(OFS_IRQ_STAT, 16'h0001);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(irq, 1'b0)
        // Slave 3 falls silent while masked: first miss is an error, the second drops it.
        wr(OFS_IRQ_MASK, 16'h0000);
        alive <= 16'h0004;
        wait_reg(OFS_ERR_PULSE, 16'h0008, 16'h0008);
        rd(OFS_ONLINE, 1'b1, 16'h000c, d);
        `CHK(link_offline, 1'b0)
        wait_reg(OFS_ONLINE, 16'hffff, 16'h0004);
        rd(OFS_IRQ_STAT, 1'b1, 16'h0006, d);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 16'h0007);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(irq, 1'b1)
        wr(OFS_IRQ_STAT, 16'h0007);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(irq, 1'b0)
        wait_reg(OFS_ERR_PULSE, 16'hffff, 16'h0000);
        rd(OFS_ERR_PULSE, 1'b1, 16'h0000, d);
        // Deregistering the only online slave must clear its online bit at once.
        wr(OFS_REG_MASK, 16'h000a);
        rd(OFS_REG_MASK, 1'b1, 16'h000a, d);
        rd(OFS_ONLINE, 1'b1, 16'h0000, d);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(link_offline, 1'b1)
        repeat (4) @(posedge ref_clk);
        end_sim();
    end
endmodule : tb
